//--- shared/ebc_regs.vh
// Constants for the external bus controller: modes, fields, timing.
`ifndef EBC_REGS_VH
`define EBC_REGS_VH
// Bus mode encodings (bus_mode_in)
`define EBC_MODE_DEMUX16 2'h0
`define EBC_MODE_MUX16 2'h1
`define EBC_MODE_MUX8 2'h2
`define EBC_MODE_DEMUX8 2'h3
// Address space size encodings (addr_space_in)
`define EBC_SPACE_16M 2'h0
`define EBC_SPACE_1M 2'h1
`define EBC_SPACE_256K 2'h2
`define EBC_SPACE_64K 2'h3
// Bus configuration word fields (one 16-bit word per window)
`define EBC_CFG_CYCLE_LSB 0
`define EBC_CFG_CYCLE_MSB 3
`define EBC_CFG_TRI_LSB 4
`define EBC_CFG_TRI_MSB 5
`define EBC_CFG_ALE_LSB 6
`define EBC_CFG_ALE_MSB 7
`define EBC_CFG_RWDLY 8
`define EBC_CFG_RDYEN 9
`define EBC_CFG_RDY_LEVEL 10
`define EBC_CFG_BUSACT 11
`define EBC_CFG_CSEN 12
// Range select fields: base in bits 15..4 (4 KB units), size code 3..0
`define EBC_RSEL_SIZE_MSB 3
`define EBC_RSEL_BASE_LSB 4
// Reset value of the default configuration word
`define EBC_CFG_RESET 16'h1a0f
`endif

//--- rtl/ebc_ext_bus_ctrl.v
// External bus controller: windows, chip selects, ready, hold arbitration.
// Summary of operation
// R01: Single-chip or four external bus modes
// R02: Demux: address port, data on data port
// R03: Mux: one port carries address then data
// R04: Cycle, tristate, strobe, delay are programmable
// R05: Four windows, range plus config pairs
// R06: Window four beats three, two beats one
// R07: Unmatched address uses default config zero
// R08: Five chip selects: windows plus default
// R09: Ready enabled: wait for active ready
// R10: Ready polarity per window config
// R11: Arbitration off until enable bit set
// R12: Master after reset; direction bit selects slave
// R13: Space limit sets upper address lines
// R14: Chip select one clock late unless early
// R15: Other master uses bus only when granted
// R16: Finish cycle, then float and acknowledge hold on one edge
`include "ebc_regs.vh"
`default_nettype none
module ebc_ext_bus_ctrl
(
  input wire clk_in,
  input wire rst_in,
  // Static configuration from software
  input wire ext_enable_in,
  input wire [1:0] bus_mode_in,
  input wire [1:0] addr_space_in,
  input wire cs_early_timing_in,
  input wire arbitration_enable_in,
  input wire arb_slave_select_dir_in,
  input wire [15:0] default_bus_config_in,
  input wire [63:0] window_bus_config_in,
  input wire [63:0] window_range_select_in,
  // CPU access request
  input wire req_in,
  input wire req_write_in,
  input wire [23:0] req_addr_in,
  input wire [15:0] req_wdata_in,
  output wire req_ready_out,
  output reg done_out,
  output reg [15:0] rdata_out,
  // Pins
  output reg [15:0] muxed_ad_port_out,
  output reg muxed_ad_port_oe_n_out,
  input wire [15:0] muxed_ad_port_in,
  output reg [15:0] demux_address_port_out,
  output reg [7:0] upper_addr_out,
  output reg addr_oe_n_out,
  output reg ale_out,
  output reg rd_n_out,
  output reg wr_n_out,
  output reg [4:0] chip_select_n_out,
  input wire ready_pin_in,
  input wire hold_n_in,
  output reg bus_request_n_out,
  output reg hold_ack_n_out,
  output reg hold_ack_oe_n_out,
  input wire hold_ack_n_in,
  output reg bus_granted_out
);
////////////////////////////////////////////////////////////////////////////
// Window match: base in 4 KB units, size code gives 4 KB << code
function match;
  input [15:0] rsel;
  input [23:0] addr;
  reg [11:0] mask;
  begin
    mask = 12'hfff << rsel[`EBC_RSEL_SIZE_MSB:0];
    match = ((addr[23:12] ^ rsel[15:`EBC_RSEL_BASE_LSB]) & mask) == 12'h000;
  end
endfunction
////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'h0;
localparam ST_ALE = 3'h1;
localparam ST_DLY = 3'h2;
localparam ST_CMD = 3'h3;
localparam ST_TRI = 3'h4;
localparam ST_HOLD = 3'h5;
reg [2:0] state_reg; // Cycle sequencer state
reg [3:0] cnt_reg; // Phase counter
reg [15:0] cfg_reg; // Config latched for the cycle
reg [4:0] cs_sel_reg; // Chip select chosen for the cycle
reg cs_late_reg; // Chip select waiting one clock
reg write_reg; // Cycle direction
reg [23:0] addr_reg; // Cycle address
reg [15:0] wdata_reg; // Cycle write data
reg [1:0] mode_reg; // Mode for the cycle
// Two-flop synchronisers for pins
reg rdy_s1_reg, rdy_s2_reg;
reg hold_s1_reg, hold_s2_reg;
reg grant_s1_reg, grant_s2_reg;
always @(posedge clk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    rdy_s1_reg <= 1'b0;
    rdy_s2_reg <= 1'b0;
    hold_s1_reg <= 1'b1;
    hold_s2_reg <= 1'b1;
    grant_s1_reg <= 1'b1;
    grant_s2_reg <= 1'b1;
  end
  else
  begin
    rdy_s1_reg <= ready_pin_in;
    rdy_s2_reg <= rdy_s1_reg;
    hold_s1_reg <= hold_n_in;
    hold_s2_reg <= hold_s1_reg;
    grant_s1_reg <= hold_ack_n_in;
    grant_s2_reg <= grant_s1_reg;
  end
end
////////////////////////////////////////////////////////////////////////////
// Window selection; later checks give priority
reg [15:0] sel_cfg;
reg [4:0] sel_cs;
integer w;
always @*
begin
  sel_cfg = default_bus_config_in; // R07
  sel_cs = 5'h01; // R07
  // Pair one/two then three/four: higher index wins on overlap
  for (w = 0; w < 4; w = w + 1)
  begin
    if (window_bus_config_in[16*w+`EBC_CFG_BUSACT] &&
        match(window_range_select_in[16*w +: 16], req_addr_in)) // R05
    begin
      sel_cfg = window_bus_config_in[16*w +: 16]; // R06
      sel_cs = 5'h02 << w; // R08
    end
  end
end
// Slave mode flips hold acknowledge to an input
wire slave_mode = arb_slave_select_dir_in; // R12
// In slave mode the master grants us the bus via hold_ack
wire want_hold = arbitration_enable_in && !slave_mode && !hold_s2_reg; // R11
wire slave_blocked = arbitration_enable_in && slave_mode &&
  grant_s2_reg; // R12
wire ready_active = (rdy_s2_reg == cfg_reg[`EBC_CFG_RDY_LEVEL]); // R10
wire mux_mode = (mode_reg == `EBC_MODE_MUX16) ||
  (mode_reg == `EBC_MODE_MUX8);
wire byte_mode = (mode_reg == `EBC_MODE_MUX8) ||
  (mode_reg == `EBC_MODE_DEMUX8);
// Requests are taken only in idle with the bus free; single-chip refuses
assign req_ready_out = (state_reg == ST_IDLE) && ext_enable_in &&
  !want_hold && !slave_blocked; // R01
////////////////////////////////////////////////////////////////////////////
// Upper address lines masked by the space limit
function [7:0] upper_mask;
  input [1:0] sp;
  begin
    case (sp)
      `EBC_SPACE_16M: upper_mask = 8'hff;
      `EBC_SPACE_1M: upper_mask = 8'h0f;
      `EBC_SPACE_256K: upper_mask = 8'h03;
      default: upper_mask = 8'h00;
    endcase
  end
endfunction
////////////////////////////////////////////////////////////////////////////
// Cycle sequencer
always @(posedge clk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    state_reg <= ST_IDLE;
    cnt_reg <= 4'h0;
    cfg_reg <= `EBC_CFG_RESET;
    cs_sel_reg <= 5'h00;
    cs_late_reg <= 1'b0;
    write_reg <= 1'b0;
    addr_reg <= 24'h000000;
    wdata_reg <= 16'h0000;
    mode_reg <= 2'h0;
    done_out <= 1'b0;
    rdata_out <= 16'h0000;
    bus_granted_out <= 1'b0;
  end
  else
  begin
    done_out <= 1'b0;
    cs_late_reg <= 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (want_hold)
        begin
          state_reg <= ST_HOLD; // R16
        end
        else if (req_in && req_ready_out)
        begin
          cfg_reg <= sel_cfg;
          cs_sel_reg <= sel_cfg[`EBC_CFG_CSEN] ? sel_cs : 5'h00;
          cs_late_reg <= !cs_early_timing_in; // R14
          write_reg <= req_write_in;
          addr_reg <= req_addr_in;
          wdata_reg <= req_wdata_in;
          mode_reg <= bus_mode_in;
          cnt_reg <= {2'b00, sel_cfg[`EBC_CFG_ALE_MSB:`EBC_CFG_ALE_LSB]};
          state_reg <= ST_ALE;
        end
      end
      ST_ALE:
      begin
        // Strobe length: one cycle plus programmed extension
        if (cnt_reg == 4'h0)
        begin
          cnt_reg <= {3'b000, cfg_reg[`EBC_CFG_RWDLY]};
          state_reg <= ST_DLY; // R04
        end
        else
          cnt_reg <= cnt_reg - 4'h1;
      end
      ST_DLY:
      begin
        if (cnt_reg == 4'h0)
        begin
          cnt_reg <= cfg_reg[`EBC_CFG_CYCLE_MSB:`EBC_CFG_CYCLE_LSB];
          state_reg <= ST_CMD;
        end
        else
          cnt_reg <= cnt_reg - 4'h1;
      end
      ST_CMD:
      begin
        // Wait states first, then ready if enabled
        if (cnt_reg != 4'h0)
          cnt_reg <= cnt_reg - 4'h1; // R04
        // With no wait states the strobe is not on the pin yet
        else if (rd_n_out && wr_n_out)
          cnt_reg <= 4'h0; // R04
        else if (!cfg_reg[`EBC_CFG_RDYEN] || ready_active) // R09
        begin
          if (!write_reg)
            rdata_out <= byte_mode ? {8'h00, muxed_ad_port_in[7:0]} :
              muxed_ad_port_in; // R02
          done_out <= 1'b1;
          cnt_reg <= {2'b00, cfg_reg[`EBC_CFG_TRI_MSB:`EBC_CFG_TRI_LSB]};
          state_reg <= ST_TRI;
        end
      end
      ST_TRI:
      begin
        // Tristate time before the next cycle may drive the port
        if (cnt_reg == 4'h0)
        begin
          cs_sel_reg <= 5'h00;
          state_reg <= ST_IDLE;
        end
        else
          cnt_reg <= cnt_reg - 4'h1; // R04
      end
      ST_HOLD:
      begin
        // Released once hold is withdrawn or arbitration is switched off
        if (hold_s2_reg || !arbitration_enable_in)
          state_reg <= ST_IDLE; // R16
      end
      default:
        state_reg <= ST_IDLE;
    endcase
    bus_granted_out <= (state_reg == ST_HOLD);
  end
end
////////////////////////////////////////////////////////////////////////////
// Pin drivers, registered
wire cyc = (state_reg == ST_ALE) || (state_reg == ST_DLY) ||
  (state_reg == ST_CMD);
always @(posedge clk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    muxed_ad_port_out <= 16'h0000;
    muxed_ad_port_oe_n_out <= 1'b1;
    demux_address_port_out <= 16'h0000;
    upper_addr_out <= 8'h00;
    addr_oe_n_out <= 1'b1;
    ale_out <= 1'b0;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    chip_select_n_out <= 5'h1f;
    bus_request_n_out <= 1'b1;
    hold_ack_n_out <= 1'b1;
    hold_ack_oe_n_out <= 1'b0;
  end
  else
  begin
    ale_out <= (state_reg == ST_ALE);
    rd_n_out <= !((state_reg == ST_CMD) && !write_reg);
    wr_n_out <= !((state_reg == ST_CMD) && write_reg);
    // Chip select held off while the late one-clock delay runs
    if (!cs_late_reg)
      chip_select_n_out <= ~cs_sel_reg; // R14
    if (state_reg == ST_HOLD)
    begin
      addr_oe_n_out <= 1'b1; // R16
      muxed_ad_port_oe_n_out <= 1'b1;
    end
    else if (cyc)
    begin
      addr_oe_n_out <= 1'b0;
      upper_addr_out <= addr_reg[23:16] & upper_mask(addr_space_in); // R13
      if (mux_mode && state_reg == ST_ALE)
      begin
        muxed_ad_port_out <= addr_reg[15:0]; // R03
        muxed_ad_port_oe_n_out <= 1'b0;
      end
      else
      begin
        demux_address_port_out <= mux_mode ? 16'h0000 : addr_reg[15:0];
        muxed_ad_port_out <= byte_mode ? {8'h00, wdata_reg[7:0]} :
          wdata_reg; // R02
        muxed_ad_port_oe_n_out <= !write_reg; // R03
      end
    end
    else
      muxed_ad_port_oe_n_out <= 1'b1;
    hold_ack_oe_n_out <= slave_mode; // R12
    hold_ack_n_out <= !(state_reg == ST_HOLD); // R16
    bus_request_n_out <= !(want_hold && state_reg == ST_HOLD); // R11
  end
end
endmodule
`default_nettype wire

//--- verification/ebc_chk.sv
// Pin-level assertions for the external bus controller
`default_nettype none
module ebc_chk (
  input wire clk_in,
  input wire rst_in,
  input wire ext_enable_in,
  input wire [1:0] addr_space_in,
  input wire cs_early_timing_in,
  input wire arbitration_enable_in,
  input wire arb_slave_select_dir_in,
  input wire req_ready_out,
  input wire done_out,
  input wire muxed_ad_port_oe_n_out,
  input wire [7:0] upper_addr_out,
  input wire addr_oe_n_out,
  input wire ale_out,
  input wire rd_n_out,
  input wire wr_n_out,
  input wire [4:0] chip_select_n_out,
  input wire hold_ack_n_out,
  input wire hold_ack_oe_n_out,
  input wire bus_granted_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks run on the one system clock
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_single_chip:
    assert property (!ext_enable_in |-> !req_ready_out)
    else $error("request accepted in single-chip mode");
  a_strobe_excl:
    assert property (!(!rd_n_out && !wr_n_out))
    else $error("read and write strobes low together");
  a_read_float:
    assert property (!rd_n_out |-> muxed_ad_port_oe_n_out)
    else $error("data port driven during read");
  a_ale_addr:
    assert property (ale_out |-> !addr_oe_n_out)
    else $error("latch strobe without address driven");
  a_cs_single:
    assert property ($countones(~chip_select_n_out) <= 1)
    else $error("more than one chip select active");
  a_done_pulse:
    assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_arb_off:
    assert property ((!arbitration_enable_in)[*3] |-> !bus_granted_out)
    else $error("bus given away with arbitration off");
  a_slave_dir:
    assert property ($stable(arb_slave_select_dir_in)[*3]
      |-> hold_ack_oe_n_out == arb_slave_select_dir_in)
    else $error("hold acknowledge direction wrong");
  a_space_mask:
    assert property (ale_out && addr_space_in == 2'h3
      |-> upper_addr_out == 8'h00)
    else $error("upper address driven in 64K space");
  a_cs_late:
    assert property ($rose(ale_out) && !cs_early_timing_in
      |-> $stable(chip_select_n_out))
    else $error("chip select moved with latch strobe in late mode");
  a_hold_float:
    assert property (!hold_ack_n_out && !hold_ack_oe_n_out
      |-> muxed_ad_port_oe_n_out && addr_oe_n_out && rd_n_out && wr_n_out)
    else $error("bus driven while hold acknowledged");
  c_done: cover property (done_out && !rd_n_out);
  c_hold: cover property (!hold_ack_n_out);
  c_win4: cover property (!chip_select_n_out[4]);
endmodule
bind ebc_ext_bus_ctrl ebc_chk ebc_chk_inst (.clk_in, .rst_in, .ext_enable_in,
  .addr_space_in, .cs_early_timing_in, .arbitration_enable_in,
  .arb_slave_select_dir_in, .req_ready_out, .done_out, .muxed_ad_port_oe_n_out,
  .upper_addr_out, .addr_oe_n_out, .ale_out, .rd_n_out, .wr_n_out,
  .chip_select_n_out, .hold_ack_n_out, .hold_ack_oe_n_out, .bus_granted_out);
`default_nettype wire

//--- verification/ebc_mem_model.sv
// External memory and ready source on the far side of the bus
`default_nettype none
module ebc_mem_model (
  input wire logic clk_in,
  input wire logic ale_in,
  input wire logic ad_oe_n_in,
  input wire logic [15:0] ad_in,
  input wire logic [15:0] demux_addr_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic stall_in,
  input wire logic ready_pol_in,
  output logic [15:0] ad_out,
  output logic ready_out,
  output logic [15:0] last_wr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] addr_lat = 16'h0000; // Address latched at the strobe
  logic [15:0] idle_val = 16'h0000; // Toggles: a released bus looks stale
  // Address comes from the shared port when the controller drives it
  always @(posedge clk_in)
  begin
    if (ale_in)
      addr_lat <= ad_oe_n_in ? demux_addr_in : ad_in;
    if (!wr_n_in && !ad_oe_n_in)
      last_wr_out <= ad_in;
    idle_val <= ~ad_out;
  end
  assign ad_out = !rd_n_in ? {addr_lat[7:0] ^ 8'h5a, addr_lat[15:8]} :
    idle_val;
  // Stall holds ready at its inactive level
  assign ready_out = stall_in ? ~ready_pol_in : ready_pol_in;
endmodule
`default_nettype wire

//--- verification/ebc_ext_bus_ctrl_test.sv
// Self-checking bench for the external bus controller
`include "ebc_regs.vh"
`default_nettype none
`define EBC_CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ebc_ext_bus_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, rst_in = 1, ext_enable_in = 1, cs_early_timing_in = 0;
  logic arbitration_enable_in = 0, arb_slave_select_dir_in = 0, req_in = 0;
  logic req_write_in = 0, hold_n_in = 1, hold_ack_n_in = 1, stall = 0, pol = 0;
  logic [1:0] bus_mode_in = `EBC_MODE_DEMUX16, addr_space_in = 2'h0;
  logic [15:0] default_bus_config_in = 16'h1801, req_wdata_in = 16'h0000;
  logic [63:0] window_bus_config_in = {4{16'h1801}};
  logic [63:0] window_range_select_in =
    {16'h0100, 16'h0104, 16'h0200, 16'h0204};
  logic [23:0] req_addr_in = 24'h000000;
  logic [15:0] muxed_ad_port_in, rdata_out, muxed_ad_port_out, last_wr;
  logic [15:0] demux_address_port_out, ad_cap, dm_cap;
  logic [7:0] upper_addr_out, up_cap;
  logic [4:0] chip_select_n_out, cs_ale, cs_cmd;
  logic req_ready_out, done_out, muxed_ad_port_oe_n_out, addr_oe_n_out;
  logic rd_n_out, wr_n_out, bus_request_n_out, hold_ack_n_out, ready_pin_in;
  logic hold_ack_oe_n_out, bus_granted_out, ale_out, in_acc = 0;
  logic [23:0] wa [4] = '{24'h010100, 24'h018000, 24'h020010, 24'h028000};
  logic [4:0] wcs [4] = '{5'h0f, 5'h17, 5'h1b, 5'h1d};
  logic [7:0] sm [4] = '{8'hff, 8'h0f, 8'h03, 8'h00};
  int fail_count = 0, checks = 0, cyc, base;
  ebc_ext_bus_ctrl ebc_ext_bus_ctrl_inst (.clk_in, .rst_in, .ext_enable_in,
    .bus_mode_in, .addr_space_in, .cs_early_timing_in, .arbitration_enable_in,
    .arb_slave_select_dir_in, .default_bus_config_in, .window_bus_config_in,
    .window_range_select_in, .req_in, .req_write_in, .req_addr_in,
    .req_wdata_in, .req_ready_out, .done_out, .rdata_out, .muxed_ad_port_out,
    .muxed_ad_port_oe_n_out, .muxed_ad_port_in, .demux_address_port_out,
    .upper_addr_out, .addr_oe_n_out, .ale_out, .rd_n_out, .wr_n_out,
    .chip_select_n_out, .ready_pin_in, .hold_n_in, .bus_request_n_out,
    .hold_ack_n_out, .hold_ack_oe_n_out, .hold_ack_n_in, .bus_granted_out);
  ebc_mem_model ebc_mem_model_inst (.clk_in, .ale_in(ale_out),
    .ad_oe_n_in(muxed_ad_port_oe_n_out), .ad_in(muxed_ad_port_out),
    .demux_addr_in(demux_address_port_out), .rd_n_in(rd_n_out),
    .wr_n_in(wr_n_out), .stall_in(stall), .ready_pol_in(pol),
    .ad_out(muxed_ad_port_in), .ready_out(ready_pin_in),
    .last_wr_out(last_wr));
  initial forever #10 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  // One bus access; pins captured at the strobe and during the command
  task automatic access(input logic w, input logic [23:0] a,
    input logic [15:0] d);
    int n;
    begin
      n = 0;
      in_acc = 1;
      @(negedge clk_in);
      {req_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, w, a, d};
      // Ready is looked at off the edge: it falls in the step that takes us
      while (req_ready_out !== 1'b1 && n < 50)
      begin
        @(negedge clk_in);
        n++;
      end
      @(negedge clk_in);
      req_in = 0;
      cyc = 1;
      cs_ale = 5'h1f;
      while (done_out !== 1'b1 && cyc < 200)
      begin
        if (ale_out === 1'b1 && cs_ale === 5'h1f)
          {cs_ale, ad_cap, dm_cap, up_cap} = {chip_select_n_out,
            muxed_ad_port_out, demux_address_port_out, upper_addr_out};
        if (rd_n_out === 1'b0 || wr_n_out === 1'b0)
          cs_cmd = chip_select_n_out;
        @(negedge clk_in);
        cyc++;
      end
      in_acc = 0;
      // Tristate phase must pass before the next request
      repeat (4) @(negedge clk_in);
    end
  endtask
  task wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge clk_in);
    rst_in = 0;
    access(0, 24'h050a3c, 0);
    `EBC_CHK(rdata_out, 16'h660a)
    `EBC_CHK(dm_cap, 16'h0a3c)
    `EBC_CHK(cs_cmd, 5'h1e)
    `EBC_CHK(cs_ale, 5'h1f)
    base = cyc;
    for (int i = 0; i < 4; i++)
    begin
      access(0, wa[i], 0);
      `EBC_CHK(cs_cmd, wcs[i])
    end
    default_bus_config_in = 16'h1805;
    access(0, 24'h050000, 0);
    `EBC_CHK(cyc - base, 4)
    bus_mode_in = `EBC_MODE_MUX16;
    access(1, 24'h05beef, 16'h1234);
    `EBC_CHK(ad_cap, 16'hbeef)
    `EBC_CHK(last_wr, 16'h1234)
    bus_mode_in = `EBC_MODE_MUX8;
    access(1, 24'h05cafe, 16'h5678);
    `EBC_CHK(last_wr[7:0], 8'h78)
    bus_mode_in = `EBC_MODE_DEMUX8;
    access(0, 24'h050a3c, 0);
    `EBC_CHK(rdata_out, 16'h000a)
    bus_mode_in = `EBC_MODE_DEMUX16;
    for (int i = 0; i < 4; i++)
    begin
      addr_space_in = i[1:0];
      access(0, 24'hf50000, 0);
      `EBC_CHK(up_cap, 8'hf5 & sm[i])
    end
    cs_early_timing_in = 1;
    access(0, 24'h010100, 0);
    `EBC_CHK(cs_ale, 5'h0f)
    cs_early_timing_in = 0;
    window_bus_config_in[9] = 1;
    for (int p = 0; p < 2; p++)
    begin
      {pol, stall, window_bus_config_in[10]} = {p[0], 1'b1, p[0]};
      fork
        access(0, 24'h028000, 0);
        begin
          repeat (30) @(negedge clk_in);
          `EBC_CHK(in_acc, 1'b1)
          stall = 0;
        end
      join
      `EBC_CHK(cyc < 50, 1'b1)
    end
    ext_enable_in = 0;
    req_in = 1;
    repeat (3) @(negedge clk_in);
    `EBC_CHK(req_ready_out, 1'b0)
    {req_in, ext_enable_in, hold_n_in} = 3'b010;
    repeat (10) @(negedge clk_in);
    `EBC_CHK({hold_ack_n_out, bus_request_n_out}, 2'b11)
    arbitration_enable_in = 1;
    repeat (10) @(negedge clk_in);
    `EBC_CHK({hold_ack_n_out, muxed_ad_port_oe_n_out, addr_oe_n_out,
      req_ready_out, bus_granted_out}, 5'h0d)
    hold_n_in = 1;
    repeat (10) @(negedge clk_in);
    `EBC_CHK(hold_ack_n_out, 1'b1)
    access(0, 24'h050a3c, 0);
    `EBC_CHK(rdata_out, 16'h660a)
    `EBC_CHK(hold_ack_oe_n_out, 1'b0)
    arb_slave_select_dir_in = 1;
    repeat (5) @(negedge clk_in);
    `EBC_CHK(hold_ack_oe_n_out, 1'b1)
    // Slave without a grant may not start a cycle
    `EBC_CHK(req_ready_out, 1'b0)
    hold_ack_n_in = 0;
    repeat (3) @(negedge clk_in);
    access(0, 24'h051234, 0);
    `EBC_CHK(rdata_out, 16'h6e12)
    wrap_up;
  end
  // Whole sequence needs well under 2000 cycles
  initial
  begin
    #200000;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
